// File: design/lbc_consts.vh
// Constants for the logic, bit and compare execution datapath.
// Included by the datapath files; definitions only.
`ifndef LBC_CONSTS_VH
`define LBC_CONSTS_VH

// Operation codes (op input)
`define LBC_OP_AND 4'h0
`define LBC_OP_OR 4'h1
`define LBC_OP_XOR 4'h2
`define LBC_OP_COMPARE 4'h3
`define LBC_OP_BIT_CLEAR 4'h4
`define LBC_OP_BIT_SET 4'h5
`define LBC_OP_BIT_MOVE 4'h6
`define LBC_OP_BIT_MOVE_NEG 4'h7
`define LBC_OP_BIT_AND 4'h8
`define LBC_OP_BIT_OR 4'h9
`define LBC_OP_BIT_XOR 4'hA
`define LBC_OP_BIT_COMPARE 4'hB
`define LBC_OP_FLDH 4'hC
`define LBC_OP_FLDL 4'hD

// Source operand forms (src_mode input)
`define LBC_SRC_GPR 3'h0
`define LBC_SRC_IND 3'h1
`define LBC_SRC_INDINC 3'h2
`define LBC_SRC_IMM3 3'h3
`define LBC_SRC_IMM 3'h4
`define LBC_SRC_MEM 3'h5

// Destination forms
`define LBC_DST_REG 1'h0
`define LBC_DST_MEM 1'h1

// Pointer steps
`define LBC_STEP_WORD 16'h0002
`define LBC_STEP_BYTE 16'h0001

// Encoding lengths in bytes
`define LBC_LEN_SHORT 3'h2
`define LBC_LEN_LONG 3'h4

// Flag positions in flags output
`define LBC_FLG_N 0
`define LBC_FLG_C 1
`define LBC_FLG_V 2
`define LBC_FLG_Z 3
`define LBC_FLG_E 4

// Reset values
`define LBC_RST_WORD 16'h0000
`define LBC_RST_FLAGS 5'h00
`define LBC_RST_LEN 3'h0

`endif

// File: design/lbc_bitop.v
// Single-bit Boolean unit: combines source and destination bits.
// Pure combinational; caller picks the bit positions.
`timescale 1ns/10ps
`default_nettype none

module lbc_bitop (
  // Operation
  input wire [3:0] op,
  // Operand bits
  input wire src_bit,
  input wire dst_bit,
  // Result
  output reg res_bit,
  output reg writes
);

`include "lbc_consts.vh"

always @* begin
  res_bit = dst_bit;
  writes = 1'b1;
  case (op)
    `LBC_OP_BIT_CLEAR: res_bit = 1'b0;
    `LBC_OP_BIT_SET: res_bit = 1'b1;
    `LBC_OP_BIT_MOVE: res_bit = src_bit;
    `LBC_OP_BIT_MOVE_NEG: res_bit = ~src_bit;
    `LBC_OP_BIT_AND: res_bit = dst_bit & src_bit;
    `LBC_OP_BIT_OR: res_bit = dst_bit | src_bit;
    `LBC_OP_BIT_XOR: res_bit = dst_bit ^ src_bit;
    `LBC_OP_BIT_COMPARE: writes = 1'b0;
    default: writes = 1'b0;
  endcase
end

endmodule

`default_nettype wire

// File: design/lbc_datapath.v
// Execution datapath for logical, bit and compare instruction groups.
// Assumes decode supplies op, operand form and fetched operands in one
// request cycle; results and write strobes follow one cycle later.
`timescale 1ns/10ps
`default_nettype none

module lbc_datapath (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Request
  input wire req_valid,
  input wire [3:0] op,
  input wire byte_op,
  input wire [2:0] src_mode,
  input wire dst_mem,
  input wire [15:0] dst_val,
  input wire [15:0] src_val,
  input wire [2:0] short_immediate,
  input wire [15:0] long_immediate,
  input wire [15:0] ptr_val,
  input wire [3:0] dst_bitpos,
  input wire [3:0] src_bitpos,
  // Result
  output reg done_ff,
  output reg [15:0] result_ff,
  output reg reg_we_ff,
  output reg mem_we_ff,
  output reg byte_we_ff,
  output reg ptr_we_ff,
  output reg [15:0] ptr_next_ff,
  output reg [4:0] flags_ff,
  output reg [2:0] length_ff
);

`include "lbc_consts.vh"

// --------------------------------------------------
// Operand selection
// --------------------------------------------------
reg [15:0] opnd;
wire [15:0] byte_immediate;
wire [7:0] byte_field_mask;

assign byte_immediate = {8'h00, long_immediate[7:0]};
assign byte_field_mask = long_immediate[15:8];

always @* begin
  case (src_mode)
    `LBC_SRC_IMM3: opnd = {13'h0000, short_immediate};
    `LBC_SRC_IMM: opnd = byte_op ? byte_immediate
                                 : long_immediate;
    default: opnd = src_val;
  endcase
end

// --------------------------------------------------
// Bit unit
// --------------------------------------------------
wire src_bit;
wire dst_bit;
wire bit_res;
wire bit_writes;

assign src_bit = src_val[src_bitpos];
assign dst_bit = dst_val[dst_bitpos];

lbc_bitop u_bitop (
  .op(op),
  .src_bit(src_bit),
  .dst_bit(dst_bit),
  .res_bit(bit_res),
  .writes(bit_writes)
);

// --------------------------------------------------
// Masked byte-field merge
// --------------------------------------------------
wire [15:0] fmask;
wire [15:0] fdata;
wire [15:0] field_word;

// Mask steers the field into the upper or lower byte
assign fmask = (op == `LBC_OP_FLDH) ?
               {byte_field_mask, 8'h00} :
               {8'h00, byte_field_mask};
// Data byte sits in both halves; the mask picks one
assign fdata = {long_immediate[7:0], long_immediate[7:0]};

genvar gi;
generate
  for (gi = 0; gi < 16; gi = gi + 1) begin : g_field
    // Unmasked bits keep the old word
    assign field_word[gi] = fmask[gi] ? fdata[gi] : dst_val[gi];
  end
endgenerate

// --------------------------------------------------
// Result and flag computation
// --------------------------------------------------
reg [15:0] nxt_result;
reg [16:0] diff;
reg nxt_reg_we;
reg nxt_mem_we;
reg [4:0] nxt_flags;
reg sign;
reg zero;

always @* begin
  nxt_result = dst_val;
  nxt_reg_we = 1'b0;
  nxt_mem_we = 1'b0;
  nxt_flags = `LBC_RST_FLAGS;
  diff = 17'h00000;
  sign = 1'b0;
  zero = 1'b0;
  case (op)
    `LBC_OP_AND, `LBC_OP_OR, `LBC_OP_XOR: begin
      if (op == `LBC_OP_AND)
        nxt_result = dst_val & opnd;
      else if (op == `LBC_OP_OR)
        nxt_result = dst_val | opnd;
      else
        nxt_result = dst_val ^ opnd;
      if (byte_op)
        nxt_result = {dst_val[15:8], nxt_result[7:0]};
      nxt_reg_we = ~dst_mem;
      nxt_mem_we = dst_mem;
      sign = byte_op ? nxt_result[7] : nxt_result[15];
      zero = byte_op ? (nxt_result[7:0] == 8'h00)
                     : (nxt_result == 16'h0000);
      nxt_flags[`LBC_FLG_N] = sign;
      nxt_flags[`LBC_FLG_Z] = zero;
    end
    `LBC_OP_COMPARE: begin
      if (byte_op)
        diff = {9'h000, dst_val[7:0]} - {9'h000, opnd[7:0]};
      else
        diff = {1'b0, dst_val} - {1'b0, opnd};
      if (byte_op) begin
        sign = diff[7];
        zero = (diff[7:0] == 8'h00);
        nxt_flags[`LBC_FLG_C] = diff[8];
        nxt_flags[`LBC_FLG_V] = (dst_val[7] ^ opnd[7]) &
                                (dst_val[7] ^ diff[7]);
      end else begin
        sign = diff[15];
        zero = (diff[15:0] == 16'h0000);
        nxt_flags[`LBC_FLG_C] = diff[16];
        nxt_flags[`LBC_FLG_V] = (dst_val[15] ^ opnd[15]) &
                                (dst_val[15] ^ diff[15]);
      end
      nxt_flags[`LBC_FLG_N] = sign;
      nxt_flags[`LBC_FLG_Z] = zero;
      nxt_flags[`LBC_FLG_E] = 1'b0;
    end
    `LBC_OP_FLDH, `LBC_OP_FLDL: begin
      nxt_result = field_word;
      nxt_mem_we = 1'b1;
      nxt_flags[`LBC_FLG_N] = nxt_result[15];
      nxt_flags[`LBC_FLG_Z] = (nxt_result == 16'h0000);
    end
    `LBC_OP_BIT_CLEAR, `LBC_OP_BIT_SET, `LBC_OP_BIT_MOVE,
    `LBC_OP_BIT_MOVE_NEG, `LBC_OP_BIT_AND, `LBC_OP_BIT_OR,
    `LBC_OP_BIT_XOR, `LBC_OP_BIT_COMPARE: begin
      // Only the addressed bit may change
      nxt_result[dst_bitpos] = bit_res;
      nxt_mem_we = bit_writes;
      nxt_flags[`LBC_FLG_Z] = ~dst_bit;
      nxt_flags[`LBC_FLG_N] = dst_bit ^ src_bit;
      nxt_flags[`LBC_FLG_C] = dst_bit & src_bit;
      nxt_flags[`LBC_FLG_V] = dst_bit | src_bit;
      if (op == `LBC_OP_BIT_CLEAR || op == `LBC_OP_BIT_SET) begin
        nxt_flags[`LBC_FLG_N] = dst_bit;
        nxt_flags[`LBC_FLG_C] = 1'b0;
        nxt_flags[`LBC_FLG_V] = 1'b0;
      end
    end
    default: nxt_flags = `LBC_RST_FLAGS;
  endcase
end

// --------------------------------------------------
// Pointer post-increment and encoding length
// --------------------------------------------------
reg nxt_ptr_we;
reg [15:0] nxt_ptr;
reg [2:0] nxt_len;
reg is_bitop;

always @* begin
  nxt_ptr_we = 1'b0;
  nxt_ptr = ptr_val;
  if (src_mode == `LBC_SRC_INDINC &&
      (op == `LBC_OP_AND || op == `LBC_OP_OR ||
       op == `LBC_OP_XOR || op == `LBC_OP_COMPARE)) begin
    nxt_ptr_we = 1'b1;
    nxt_ptr = ptr_val + (byte_op ? `LBC_STEP_BYTE
                                 : `LBC_STEP_WORD);
  end
  is_bitop = (op >= `LBC_OP_BIT_MOVE) && (op <= `LBC_OP_FLDL);
  if (op == `LBC_OP_BIT_CLEAR || op == `LBC_OP_BIT_SET)
    nxt_len = `LBC_LEN_SHORT;
  else if (is_bitop)
    nxt_len = `LBC_LEN_LONG;
  else if (src_mode == `LBC_SRC_IMM || src_mode == `LBC_SRC_MEM ||
           dst_mem)
    nxt_len = `LBC_LEN_LONG;
  else
    nxt_len = `LBC_LEN_SHORT;
end

// --------------------------------------------------
// Output registers
// --------------------------------------------------
always @(posedge clock or negedge rstn) begin
  if (!rstn) begin
    done_ff <= 1'b0;
    result_ff <= `LBC_RST_WORD;
    reg_we_ff <= 1'b0;
    mem_we_ff <= 1'b0;
    byte_we_ff <= 1'b0;
    ptr_we_ff <= 1'b0;
    ptr_next_ff <= `LBC_RST_WORD;
    flags_ff <= `LBC_RST_FLAGS;
    length_ff <= `LBC_RST_LEN;
  end else begin
    done_ff <= req_valid;
    reg_we_ff <= req_valid & nxt_reg_we;
    mem_we_ff <= req_valid & nxt_mem_we;
    ptr_we_ff <= req_valid & nxt_ptr_we;
    if (req_valid) begin
      result_ff <= nxt_result;
      byte_we_ff <= byte_op & (op <= `LBC_OP_COMPARE);
      ptr_next_ff <= nxt_ptr;
      flags_ff <= nxt_flags;
      length_ff <= nxt_len;
    end
  end
end

endmodule

`default_nettype wire

// File: tb/lbc_datapath_asserts.sv
// Port checker for the logic, bit and compare datapath.
// Bound into lbc_datapath; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "lbc_consts.vh"
module lbc_datapath_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Request
  input wire logic req_valid,
  input wire logic [3:0] op,
  input wire logic byte_op,
  input wire logic [2:0] src_mode,
  input wire logic dst_mem,
  input wire logic [15:0] dst_val,
  input wire logic [15:0] src_val,
  input wire logic [15:0] ptr_val,
  // Result
  input wire logic done_ff,
  input wire logic [15:0] result_ff,
  input wire logic reg_we_ff,
  input wire logic mem_we_ff,
  input wire logic ptr_we_ff,
  input wire logic [15:0] ptr_next_ff,
  input wire logic [2:0] length_ff
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire lg = req_valid && op <= `LBC_OP_COMPARE;
  wire inc = lg && src_mode == `LBC_SRC_INDINC;
  a_done_next: assert property (req_valid |=> done_ff)
    else $error("done missing");
  a_done_cause: assert property (done_ff |-> $past(req_valid))
    else $error("done without request");
  a_and_word: assert property (lg && op == `LBC_OP_AND && !byte_op
    && !dst_mem && src_mode == `LBC_SRC_GPR |=> reg_we_ff
    && result_ff == ($past(dst_val) & $past(src_val)))
    else $error("word and wrong");
  a_ptr_word: assert property (inc && !byte_op |=> ptr_we_ff
    && ptr_next_ff == $past(ptr_val) + 16'h0002)
    else $error("word pointer step wrong");
  a_ptr_byte: assert property (inc && byte_op |=> ptr_we_ff
    && ptr_next_ff == $past(ptr_val) + 16'h0001)
    else $error("byte pointer step wrong");
  a_len_short: assert property (lg && src_mode <= `LBC_SRC_IMM3
    && !dst_mem |=> length_ff == 3'h2) else $error("short length wrong");
  a_len_long: assert property (lg && src_mode >= `LBC_SRC_IMM
    |=> length_ff == 3'h4) else $error("long length wrong");
  a_compare_no_write: assert property (req_valid &&
    (op == `LBC_OP_COMPARE || op == `LBC_OP_BIT_COMPARE)
    |=> !reg_we_ff && !mem_we_ff)
    else $error("compare wrote");
  a_mem_dst: assert property (lg && op != `LBC_OP_COMPARE && dst_mem
    |=> mem_we_ff && !reg_we_ff) else $error("memory dest wrong");
  c_inc_byte: cover property (inc && byte_op);
  c_bit_compare: cover property (req_valid && op == `LBC_OP_BIT_COMPARE);
  c_mem: cover property (lg && dst_mem);
endmodule
bind lbc_datapath lbc_datapath_asserts i_chk (.clock(clock), .rstn(rstn),
  .req_valid(req_valid), .op(op), .byte_op(byte_op), .src_mode(src_mode),
  .dst_mem(dst_mem), .dst_val(dst_val), .src_val(src_val),
  .ptr_val(ptr_val), .done_ff(done_ff), .result_ff(result_ff),
  .reg_we_ff(reg_we_ff), .mem_we_ff(mem_we_ff), .ptr_we_ff(ptr_we_ff),
  .ptr_next_ff(ptr_next_ff), .length_ff(length_ff));
`default_nettype wire

// File: tb/lbc_datapath_tb.sv
// Self-checking bench for the logic, bit and compare datapath.
// Drives lbc_datapath ports directly; checker file compiled before.
`timescale 1ns/10ps
`default_nettype none
`include "lbc_consts.vh"
module lbc_datapath_tb;
  logic clock = 1'b0, rstn = 1'b0, req_valid = 1'b0;
  logic byte_op = 1'b0, dst_mem = 1'b0;
  logic [3:0] op = 4'h0, dst_bitpos = 4'h0, src_bitpos = 4'h0;
  logic [2:0] src_mode = 3'h0, short_immediate = 3'h0;
  logic [15:0] dst_val = 16'h0000, src_val = 16'h0000;
  logic [15:0] long_immediate = 16'h0000, ptr_val = 16'h0000;
  wire logic done_ff, reg_we_ff, mem_we_ff, byte_we_ff, ptr_we_ff;
  wire logic [15:0] result_ff, ptr_next_ff;
  wire logic [4:0] flags_ff;
  wire logic [2:0] length_ff;
  int error_cnt = 0, n_checks = 0;
  logic [15:0] bexp [7] = '{16'h8000, 16'h8001, 16'h8001, 16'h8000,
    16'h8000, 16'h8001, 16'h8001};
  always #25 clock = ~clock;
  lbc_datapath i_dut (.clock(clock), .rstn(rstn), .req_valid(req_valid),
    .op(op), .byte_op(byte_op), .src_mode(src_mode), .dst_mem(dst_mem),
    .dst_val(dst_val), .src_val(src_val), .ptr_val(ptr_val),
    .short_immediate(short_immediate), .long_immediate(long_immediate),
    .dst_bitpos(dst_bitpos), .src_bitpos(src_bitpos), .done_ff(done_ff),
    .result_ff(result_ff), .reg_we_ff(reg_we_ff), .mem_we_ff(mem_we_ff),
    .byte_we_ff(byte_we_ff), .ptr_we_ff(ptr_we_ff),
    .ptr_next_ff(ptr_next_ff), .flags_ff(flags_ff), .length_ff(length_ff));
  // ----
  // Shared tasks
  // ----
  task ck(input logic [19:0] s, input logic [19:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task prep(input logic [3:0] o, input logic [2:0] m, input logic [15:0] d,
    input logic [15:0] s);
    @(posedge clock);
    req_valid <= 1'b1;
    op <= o;
    src_mode <= m;
    dst_val <= d;
    src_val <= s;
  endtask
  // Back to word width and register destination after each request
  task take;
    @(posedge clock);
    req_valid <= 1'b0;
    byte_op <= 1'b0;
    dst_mem <= 1'b0;
    #1;
    ck(done_ff, 1'b1);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task s_logic;
    for (int i = 0; i < 3; i++) begin
      prep(i[3:0], `LBC_SRC_GPR, 16'hF0F0, 16'h0FF0);
      take;
      ck(result_ff, i == 0 ? 16'h00F0 : i == 1 ? 16'hFFF0 : 16'hFF00);
      ck({reg_we_ff, mem_we_ff, length_ff}, 5'h12);
    end
    for (int j = 0; j < 2; j++) begin
      prep(`LBC_OP_AND, `LBC_SRC_MEM, 16'h3C3C, 16'h0F0F);
      dst_mem <= j[0];
      take;
      ck({result_ff, reg_we_ff, mem_we_ff}, j ? 18'h3031 : 18'h3032);
      ck(length_ff, 3'h4);
    end
  endtask
  task s_ind;
    prep(`LBC_OP_AND, `LBC_SRC_INDINC, 16'hF0F0, 16'h0FF0);
    ptr_val <= 16'h0010;
    take;
    ck({ptr_we_ff, result_ff}, 17'h100F0);
    ck(ptr_next_ff, 16'h0012);
    prep(`LBC_OP_XOR, `LBC_SRC_IND, 16'h00FF, 16'h0F0F);
    take;
    ck({ptr_we_ff, result_ff}, 17'h00FF0);
    prep(`LBC_OP_OR, `LBC_SRC_INDINC, 16'h12F0, 16'hAA0F);
    byte_op <= 1'b1;
    ptr_val <= 16'hFFFF;
    take;
    ck(result_ff, 16'h12FF);
    ck({byte_we_ff, ptr_next_ff}, 17'h10000);
  endtask
  task s_imm;
    prep(`LBC_OP_AND, `LBC_SRC_IMM3, 16'h00FF, 16'h0000);
    short_immediate <= 3'h5;
    take;
    ck({result_ff, 1'b0, length_ff}, 20'h00052);
    prep(`LBC_OP_XOR, `LBC_SRC_IMM, 16'hFFFF, 16'h0000);
    long_immediate <= 16'hF00F;
    take;
    ck({result_ff, 1'b0, length_ff}, 20'h0FF04);
    prep(`LBC_OP_OR, `LBC_SRC_IMM, 16'h1200, 16'h0000);
    byte_op <= 1'b1;
    long_immediate <= 16'h0081;
    take;
    ck({result_ff, 1'b0, length_ff}, 20'h12814);
  endtask
  task s_bits;
    for (int i = 0; i < 8; i++) begin
      prep(4'h4 + i[3:0], `LBC_SRC_GPR, 16'h8000, 16'h0008);
      src_bitpos <= 4'h3;
      dst_bitpos <= 4'h0;
      take;
      if (i < 7) begin
        ck(result_ff, bexp[i]);
        ck({mem_we_ff, length_ff}, i < 2 ? 4'hA : 4'hC);
      end else
        ck({mem_we_ff, reg_we_ff, flags_ff[3:0]}, 6'h0D);
    end
    // Destination bit set, so AND keeps it and XOR clears it
    for (int k = 0; k < 2; k++) begin
      prep(k ? `LBC_OP_BIT_XOR : `LBC_OP_BIT_AND, `LBC_SRC_GPR, 16'h0001,
        16'h0008);
      take;
      ck(result_ff, k ? 16'h0000 : 16'h0001);
    end
  endtask
  task s_field;
    prep(`LBC_OP_FLDH, `LBC_SRC_IMM, 16'h1234, 16'h0000);
    long_immediate <= 16'hF0AB;
    take;
    ck({result_ff, 3'h0, mem_we_ff}, 20'hA2341);
    prep(`LBC_OP_FLDL, `LBC_SRC_IMM, 16'h1234, 16'h0000);
    long_immediate <= 16'h0F5A;
    take;
    ck({result_ff, 3'h0, mem_we_ff}, 20'h123A1);
  endtask
  task s_compare;
    prep(`LBC_OP_COMPARE, `LBC_SRC_GPR, 16'h1234, 16'h1234);
    take;
    ck({reg_we_ff, mem_we_ff, flags_ff}, 7'h08);
    prep(`LBC_OP_COMPARE, `LBC_SRC_IMM, 16'h0001, 16'h0000);
    long_immediate <= 16'h0002;
    take;
    ck({flags_ff[3:0], length_ff}, 7'h1C);
    for (int b = 0; b < 2; b++) begin
      prep(`LBC_OP_COMPARE, `LBC_SRC_INDINC, 16'h0005, 16'h0005);
      byte_op <= b[0];
      ptr_val <= 16'h0020;
      take;
      ck(ptr_next_ff, b ? 16'h0021 : 16'h0022);
    end
    prep(`LBC_OP_COMPARE, `LBC_SRC_IMM, 16'h5580, 16'h0000);
    byte_op <= 1'b1;
    long_immediate <= 16'h0080;
    take;
    ck({flags_ff[3], length_ff}, 4'hC);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    s_logic;
    s_ind;
    s_imm;
    s_bits;
    s_field;
    s_compare;
    wrap_up;
  end
  // Run needs under 100 cycles after reset
  initial begin
    #20000;
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
